// ===== hdl/frs_sequencer.sv
// reset sequencer tail: quasi-reset release, SMBus bring-up, EEPROM load, halt
//
// Overview of operation
// - release stacks into quasi-reset unless test mode
// - links start training within 20 ms
// - config requests retried within 100 ms
// - non-config traffic ignored during quasi-reset
// - slow-select strap picks 100 or 400 KHz
// - slave SMBus up, address from straps 5,3:1
// - master SMBus up after slave, before EEPROM
// - EEPROM modes load registers via master SMBus
// - EEPROM error aborts, sets halt, logs error
// - done flag set on finish or error
// - halt holds core reset, keeps SMBus/CSR/stacks
// - halt lasts until slave SMBus clears bit
// - no halt or halt cleared: normal operation
// - halt pin during sequencing sets halt bit
// - operating mode from straps at release
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module frs_sequencer
  import frs_pkg::*;
#(
  parameter int LINK_CYC = LINK_TRAIN_MS * (CLK_HZ / 1000),
  parameter int CFG_CYC = CFG_READY_MS * (CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // reset condition, straps and halt pin
  input wire logic fundamental_reset_n,
  input wire frs_straps_t straps,
  input wire logic reset_halt,
  // SMBus interface bring-up
  output logic slvSmbusEn,
  output logic [6:0] slvSmbusAddr,
  input wire logic slvInitDone,
  output logic mstSmbusEn,
  output logic mstSmbusSlow,
  input wire logic mstInitDone,
  // EEPROM loader
  output logic eeLoadGo,
  input wire logic eeLoadDone,
  input wire logic eeLoadErr,
  input wire logic [3:0] eeErrCode,
  // stacks and received traffic
  output logic stackReset_n,
  output logic linkTrainEn,
  output logic cfgRetryEn,
  input wire frs_rx_t rx,
  output logic cplRetry,
  output logic rxDrop,
  output logic rxPass,
  output logic coreReset_n,
  // register bus, reached through the slave SMBus bridge
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);
  // ****************************************************************
  // state
  // ****************************************************************
  frs_state_t state_reg, state_next;
  frs_straps_t straps_reg;
  logic freshRelease_reg;
  logic [19:0] relCnt_reg;
  logic halt_reg, haltPinSeen_reg;
  logic eeDone_reg, eeErr_reg;
  logic [3:0] eeCode_reg;
  logic [NUM_EV-1:0] evStat_reg, evEn_reg, evHit;
  logic inQuasi, isTestMode, isEeMode, sequencing;
  logic stackRelease;

  // strap decode, taken from the value latched at release
  assign isTestMode = straps_reg.opMode[TEST_MODE_BIT];
  assign isEeMode = straps_reg.opMode[EE_MODE_BIT] & ~isTestMode;
  assign sequencing = state_reg != ST_WAIT && state_reg != ST_NORMAL;
  assign inQuasi = stackRelease & (state_reg != ST_NORMAL);
  assign stackRelease = (state_reg != ST_WAIT) & ~isTestMode;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic busAck, doWrite;
  logic hitCtrl, hitEn, hitClr;
  logic [31:0] readMux;
  logic haltClrWr, haltSetWr;
  assign busAck = (avs_read | avs_write) & avs_waitrequest;
  assign doWrite = avs_write & ~avs_waitrequest;
  assign hitCtrl = doWrite & (avs_address == OFF_CTRL);
  assign hitEn = doWrite & (avs_address == OFF_IRQEN);
  assign hitClr = doWrite & (avs_address == OFF_IRQCLR);
  assign haltClrWr = hitCtrl & ~avs_writedata[CTRL_HALT_BIT];
  assign haltSetWr = hitCtrl & avs_writedata[CTRL_HALT_BIT];

  // read selection; unmapped and write-only words read zero
  always_comb begin
    readMux = RST_WORD;
    unique case (avs_address)
      OFF_CTRL: readMux[CTRL_HALT_BIT] = halt_reg;
      OFF_SWSTAT: begin
        readMux[SW_HALTPIN_BIT] = haltPinSeen_reg;
        readMux[SW_NORMAL_BIT] = state_reg == ST_NORMAL;
        readMux[SW_HALTED_BIT] = state_reg == ST_HALTED;
        readMux[SW_STATE_LSB +: 4] = state_reg;
      end
      OFF_SMBSTAT: begin
        readMux[SMB_DONE_BIT] = eeDone_reg;
        readMux[SMB_ERR_BIT] = eeErr_reg;
        readMux[SMB_CODE_LSB +: 4] = eeCode_reg;
      end
      OFF_IRQSTAT: readMux[NUM_EV-1:0] = evStat_reg;
      OFF_IRQEN: readMux[NUM_EV-1:0] = evEn_reg;
      OFF_STRAPS: readMux[8:0] = straps_reg;
      default: readMux = RST_WORD;
    endcase
  end

  // one wait cycle, then a single ready cycle with data held in a flop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= RST_WORD;
    end else begin
      avs_waitrequest <= ~busAck;
      if (busAck && avs_read) avs_readdata <= readMux;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // init steps advance only once done is reported, the load step on done or error; ST_QUASI, ST_SPEED and ST_HALT_CHK take one cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_WAIT: if (freshRelease_reg) state_next = ST_QUASI;
      ST_QUASI: state_next = ST_SPEED;
      ST_SPEED: state_next = ST_SLV_INIT;
      ST_SLV_INIT: if (slvInitDone) state_next = ST_MST_INIT;
      ST_MST_INIT: if (mstInitDone) state_next = isEeMode ? ST_EE_LOAD : ST_HALT_CHK;
      ST_EE_LOAD: if (eeLoadDone | eeLoadErr) state_next = ST_HALT_CHK;
      ST_HALT_CHK: state_next = halt_reg ? ST_HALTED : ST_NORMAL;
      ST_HALTED: if (!halt_reg) state_next = ST_NORMAL;
      ST_NORMAL: state_next = ST_NORMAL;
    endcase
  end

  // state and release flag at release of the fundamental reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !fundamental_reset_n) begin
      state_reg <= ST_WAIT;
      freshRelease_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      freshRelease_reg <= state_reg == ST_WAIT;
    end
  end

  // straps stay frozen after the sequence leaves the wait step
  always_ff @(posedge clk_sys) begin
    if (!reset_n) straps_reg <= '0;
    else if (state_reg == ST_WAIT) straps_reg <= straps;
  end

  // time since release, saturating at the config deadline
  always_ff @(posedge clk_sys) begin
    if (!reset_n || state_reg == ST_WAIT) relCnt_reg <= '0;
    else if (relCnt_reg < 20'(CFG_CYC)) relCnt_reg <= relCnt_reg + 20'h00001;
  end

  // ****************************************************************
  // halt bit and EEPROM status
  // ****************************************************************
  // hardware set wins over a clearing write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n || state_reg == ST_WAIT) begin
      halt_reg <= 1'b0;
      haltPinSeen_reg <= 1'b0;
    end else begin
      if (reset_halt && sequencing) haltPinSeen_reg <= 1'b1;
      if ((reset_halt && sequencing && state_reg != ST_HALTED) || haltSetWr)
        halt_reg <= 1'b1;
      else if (state_reg == ST_EE_LOAD && eeLoadErr) halt_reg <= 1'b1;
      else if (haltClrWr) halt_reg <= 1'b0;
    end
  end

  // done flag and error record of the EEPROM load
  always_ff @(posedge clk_sys) begin
    if (!reset_n || state_reg == ST_WAIT) begin
      eeDone_reg <= 1'b0;
      eeErr_reg <= 1'b0;
      eeCode_reg <= 4'h0;
    end else if (state_reg == ST_EE_LOAD && (eeLoadDone || eeLoadErr)) begin
      eeDone_reg <= 1'b1;
      eeErr_reg <= eeLoadErr;
      eeCode_reg <= eeLoadErr ? eeErrCode : 4'h0;
    end
  end

  // ****************************************************************
  // outputs to SMBus, loader, stacks and core
  // ****************************************************************
  logic [6:0] slvAddrNext;
  assign slvAddrNext = {SLV_ADDR_BASE[6], straps_reg.slvAddrStraps[3], SLV_ADDR_BASE[4],
                        straps_reg.slvAddrStraps[2:0], SLV_ADDR_BASE[0]};

  // enables stay up once their step is reached; loader start is a level
  always_ff @(posedge clk_sys) begin
    if (!reset_n || state_reg == ST_WAIT) begin
      mstSmbusSlow <= 1'b0;
      slvSmbusEn <= 1'b0;
      slvSmbusAddr <= SLV_ADDR_BASE;
      mstSmbusEn <= 1'b0;
      eeLoadGo <= 1'b0;
    end else begin
      if (state_reg == ST_SPEED) mstSmbusSlow <= straps_reg.masterSlowSel;
      if (state_reg == ST_SPEED) slvSmbusAddr <= slvAddrNext;
      if (state_reg == ST_SPEED) slvSmbusEn <= 1'b1;
      if (state_reg == ST_SLV_INIT && slvInitDone) mstSmbusEn <= 1'b1;
      eeLoadGo <= state_next == ST_EE_LOAD;
    end
  end

  // stacks leave reset at the first step unless in test mode; core waits for normal operation
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stackReset_n <= 1'b0;
      linkTrainEn <= 1'b0;
      cfgRetryEn <= 1'b0;
      coreReset_n <= 1'b0;
    end else begin
      stackReset_n <= stackRelease;
      linkTrainEn <= stackRelease;
      cfgRetryEn <= inQuasi;
      coreReset_n <= state_reg == ST_NORMAL;
    end
  end

  // received traffic: retry config, drop the rest until normal operation
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cplRetry <= 1'b0;
      rxDrop <= 1'b0;
      rxPass <= 1'b0;
    end else begin
      cplRetry <= rx.valid & rx.isCfg & inQuasi;
      rxDrop <= rx.valid & ~(rx.isCfg & inQuasi) & (state_reg != ST_NORMAL);
      rxPass <= rx.valid & (state_reg == ST_NORMAL);
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign evHit[EV_DONE] = state_reg == ST_EE_LOAD && (eeLoadDone || eeLoadErr);
  assign evHit[EV_ERR] = state_reg == ST_EE_LOAD && eeLoadErr;
  assign evHit[EV_HALT] = state_reg == ST_HALT_CHK && halt_reg;
  assign evHit[EV_NORMAL] = state_reg != ST_NORMAL && state_next == ST_NORMAL;

  // sticky bits; a new event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EV; gi++) begin : g_ev
      always_ff @(posedge clk_sys) begin
        if (!reset_n) evStat_reg[gi] <= 1'b0;
        else if (evHit[gi]) evStat_reg[gi] <= 1'b1;
        else if (hitClr && avs_writedata[gi]) evStat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // enable register and level interrupt
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      evEn_reg <= RST_EV;
      irq <= 1'b0;
    end else begin
      if (hitEn) evEn_reg <= avs_writedata[NUM_EV-1:0];
      irq <= |(evStat_reg & evEn_reg);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  quasi_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_QUASI && !isTestMode) |=> stackReset_n && !coreReset_n)
    else $error("stacks not released into quasi-reset");
  link_deadline_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sequencing && !isTestMode && relCnt_reg >= 20'(LINK_CYC)) |-> linkTrainEn)
    else $error("link training not started by deadline");
  cfg_retry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rx.valid && rx.isCfg && cfgRetryEn && inQuasi) |=> cplRetry)
    else $error("config request not retried");
  drop_other_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rx.valid && !rx.isCfg && state_reg != ST_NORMAL) |=> rxDrop && !cplRetry && !rxPass)
    else $error("non-config traffic not ignored");
  speed_pick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_SPEED) |=> mstSmbusSlow == $past(straps_reg.masterSlowSel))
    else $error("master SMBus speed wrong");
  slave_first_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mstSmbusEn |-> slvSmbusEn && slvSmbusAddr == slvAddrNext)
    else $error("master SMBus up before slave");
  ee_error_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_EE_LOAD && eeLoadErr && fundamental_reset_n)
      |=> halt_reg && eeDone_reg && eeErr_reg ##1 state_reg == ST_HALTED)
    else $error("EEPROM error did not halt");
  halt_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_HALTED) |-> !coreReset_n && slvSmbusEn && mstSmbusEn)
    else $error("halt state leaked core reset");
  halt_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_HALTED && !halt_reg && fundamental_reset_n)
      |=> state_reg == ST_NORMAL ##1 coreReset_n)
    else $error("halt clear did not start operation");
  strap_freeze_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg != ST_WAIT && $past(state_reg) != ST_WAIT) |-> $stable(straps_reg))
    else $error("straps changed after release");
  // bring-up outputs, status capture and the register path
  slave_addr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_SPEED) |=> slvSmbusEn && slvSmbusAddr == slvAddrNext)
    else $error("slave SMBus not set up from straps");
  ee_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_EE_LOAD) |-> eeLoadGo)
    else $error("EEPROM load step without loader start");
  ee_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == ST_EE_LOAD && (eeLoadDone || eeLoadErr)) |=> eeDone_reg)
    else $error("EEPROM done flag not set");
  halt_pin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reset_halt && sequencing && state_reg != ST_HALTED) |=> halt_reg && haltPinSeen_reg)
    else $error("halt pin not recorded");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (|(evStat_reg & evEn_reg)) |=> irq)
    else $error("enabled event without interrupt");
  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("register access not answered in one cycle");
endmodule : frs_sequencer
`default_nettype wire

// ===== inc/frs_pkg.sv
// package for the fundamental reset tail sequencer: map, fields, modes, timing
`default_nettype none
package frs_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [4:0] OFF_CTRL = 5'h00; // switch_control_reg
  localparam logic [4:0] OFF_SWSTAT = 5'h04; // switch_status_reg
  localparam logic [4:0] OFF_SMBSTAT = 5'h08; // smbus_status_reg
  localparam logic [4:0] OFF_IRQSTAT = 5'h0C; // sticky event status, read only
  localparam logic [4:0] OFF_IRQEN = 5'h10; // event enable
  localparam logic [4:0] OFF_IRQCLR = 5'h14; // write one to clear, reads zero
  localparam logic [4:0] OFF_STRAPS = 5'h18; // sampled straps, read only

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_HALT_BIT = 0;
  localparam int SW_HALTPIN_BIT = 0;
  localparam int SW_NORMAL_BIT = 1;
  localparam int SW_HALTED_BIT = 2;
  localparam int SW_STATE_LSB = 4;
  localparam int SMB_DONE_BIT = 0;
  localparam int SMB_ERR_BIT = 1;
  localparam int SMB_CODE_LSB = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ERR = 1;
  localparam int EV_HALT = 2;
  localparam int EV_NORMAL = 3;
  localparam int NUM_EV = 4;

  // ****************************************************************
  // reset values and strap decode
  // ****************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [NUM_EV-1:0] RST_EV = 4'h0;
  localparam int TEST_MODE_BIT = 3; // mode codes with this bit set are test modes
  localparam int EE_MODE_BIT = 0; // non-test mode codes with this bit set load the EEPROM
  localparam logic [6:0] SLV_ADDR_BASE = 7'h50; // fixed bits of the slave address

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int LINK_TRAIN_MS = 20;
  localparam int CFG_READY_MS = 100;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] opMode; // operating_mode_straps
    logic masterSlowSel; // master_smbus_slow_select
    logic [3:0] slvAddrStraps; // slave_smbus_addr_straps 5,3,2,1
  } frs_straps_t;

  typedef struct packed {
    logic valid;
    logic isCfg;
  } frs_rx_t;

  typedef enum logic [3:0] {
    ST_WAIT, ST_QUASI, ST_SPEED, ST_SLV_INIT, ST_MST_INIT,
    ST_EE_LOAD, ST_HALT_CHK, ST_HALTED, ST_NORMAL
  } frs_state_t;
endpackage : frs_pkg
`default_nettype wire

// ===== tb/frs_partner.sv
// far-side model: SMBus interface init handshakes and EEPROM loader replies
`timescale 1ns/100ps
`default_nettype none
module frs_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // requests from the sequencer
  input wire logic slvSmbusEn,
  input wire logic mstSmbusEn,
  input wire logic eeLoadGo,
  // behaviour chosen by the bench
  input wire logic [3:0] respDelay,
  input wire logic loadFail,
  input wire logic [3:0] failCode,
  // answers
  output logic slvInitDone,
  output logic mstInitDone,
  output logic eeLoadDone,
  output logic eeLoadErr,
  output logic [3:0] eeErrCode
);
  logic [4:0] slvCnt_reg;
  logic [4:0] mstCnt_reg;
  logic [4:0] eeCnt_reg;

  // saturating age of a request, zero while it is not standing
  function automatic logic [4:0] age(input logic en, input logic [4:0] c);
    return en ? ((c == 5'h1F) ? c : c + 5'h01) : 5'h00;
  endfunction : age

  // each step waits respDelay+1 cycles, so both prompt and slow replies occur
  always_ff @(posedge clk_sys) begin
    slvCnt_reg <= reset_n ? age(slvSmbusEn, slvCnt_reg) : 5'h00;
    mstCnt_reg <= reset_n ? age(mstSmbusEn, mstCnt_reg) : 5'h00;
    eeCnt_reg <= reset_n ? age(eeLoadGo, eeCnt_reg) : 5'h00;
  end

  // replies stand only while the request does
  assign slvInitDone = slvSmbusEn && (slvCnt_reg > {1'b0, respDelay});
  assign mstInitDone = mstSmbusEn && (mstCnt_reg > {1'b0, respDelay});
  assign eeLoadDone = eeLoadGo && (eeCnt_reg > {1'b0, respDelay}) && !loadFail;
  assign eeLoadErr = eeLoadGo && (eeCnt_reg > {1'b0, respDelay}) && loadFail;
  // no stale code outside an error: the inverse is shown instead
  assign eeErrCode = eeLoadErr ? failCode : ~failCode;
endmodule : frs_partner
`default_nettype wire

// ===== tb/fundamental_reset_init_tail_bench.sv
// self-checking bench for the reset sequencer tail with its far-side model
`timescale 1ns/100ps
`default_nettype none
module fundamental_reset_init_tail_bench;
  import frs_pkg::*;
  localparam int LINK = 20;
  localparam int CFG = 100;
  typedef struct packed {logic [31:0] mask; logic [31:0] val;} frs_note_t;
  logic clk_sys = 1'b0, reset_n = 1'b0, fundamental_reset_n = 1'b0, reset_halt = 1'b0;
  frs_straps_t straps = '0;
  frs_rx_t rx = '0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, loadFail = 1'b0, eeSeen = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'h0000_0063, q;
  logic avs_waitrequest, irq, slvSmbusEn, slvInitDone, mstSmbusEn, mstSmbusSlow, mstInitDone;
  logic eeLoadGo, eeLoadDone, eeLoadErr, stackReset_n, linkTrainEn, cfgRetryEn;
  logic cplRetry, rxDrop, rxPass, coreReset_n;
  logic [6:0] slvSmbusAddr;
  logic [3:0] eeErrCode, respDelay = 4'h3, failCode = 4'h0;
  int failures = 0, checked = 0;
  frs_note_t notes[$];
  frs_note_t nt;

  // ****************************************************************
  // clock, design and far side
  // ****************************************************************
  initial forever #50 clk_sys = ~clk_sys;
  frs_sequencer #(.LINK_CYC(LINK), .CFG_CYC(CFG)) u_dut (.clk_sys, .reset_n,
    .fundamental_reset_n, .straps, .reset_halt, .slvSmbusEn, .slvSmbusAddr, .slvInitDone,
    .mstSmbusEn, .mstSmbusSlow, .mstInitDone, .eeLoadGo, .eeLoadDone, .eeLoadErr, .eeErrCode,
    .stackReset_n, .linkTrainEn, .cfgRetryEn, .rx, .cplRetry, .rxDrop, .rxPass, .coreReset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  frs_partner u_far (.clk_sys, .reset_n, .slvSmbusEn, .mstSmbusEn, .eeLoadGo, .respDelay,
    .loadFail, .failCode, .slvInitDone, .mstInitDone, .eeLoadDone, .eeLoadErr, .eeErrCode);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // one bus access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) failures++;
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back({m, e & m});
    bus(1'b0, a, 32'h0);
  endtask : rd
  // one received transaction; e is {retry, drop, pass}
  task automatic send(input logic cfg, input logic [2:0] e);
    notes.push_back({32'h0000_0007, 29'h0, e});
    @(posedge clk_sys);
    rx <= '{valid: 1'b1, isCfg: cfg};
    @(posedge clk_sys);
    rx <= '0;
    repeat (2) @(posedge clk_sys);
  endtask : send
  task automatic waitcore;
    int n;
    n = 0;
    while (coreReset_n !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : waitcore

  // results are taken against the oldest note; a result with no note fails too
  always @(posedge clk_sys) begin
    if ((avs_read && avs_waitrequest === 1'b0) || cplRetry || rxDrop || rxPass) begin
      if (notes.size() == 0) begin
        chk1(1'b1, 1'b0);
      end else begin
        nt = notes.pop_front();
        chk((avs_read ? avs_readdata : {29'h0, cplRetry, rxDrop, rxPass}) & nt.mask, nt.val);
      end
    end
    if (eeLoadGo === 1'b1) eeSeen <= 1'b1;
    if (eeLoadGo === 1'b1 && mstInitDone !== 1'b1) chk1(1'b1, 1'b0);
    if (mstSmbusEn === 1'b1 && slvInitDone !== 1'b1) chk1(1'b1, 1'b0);
  end

  // ****************************************************************
  // one pass through the sequence for a given mode and fault
  // ****************************************************************
  task automatic run(input logic [3:0] mode, input logic pin, input logic err,
                     input logic [3:0] en);
    logic test, ee, halt;
    logic [3:0] ev;
    int n;
    test = mode[TEST_MODE_BIT];
    ee = mode[EE_MODE_BIT] && !test;
    halt = pin || (ee && err);
    ev = {1'b1, halt, ee && err, ee};
    rnd = xs(rnd);
    @(posedge clk_sys);
    fundamental_reset_n <= 1'b0;
    straps <= '{opMode: mode, masterSlowSel: rnd[4], slvAddrStraps: rnd[3:0]};
    respDelay <= rnd[11:8] | 4'h4; // init steps must outlast the two early sends
    failCode <= rnd[15:12];
    loadFail <= err;
    reset_halt <= pin;
    eeSeen <= 1'b0;
    repeat (3) @(posedge clk_sys);
    fundamental_reset_n <= 1'b1;
    n = 0;
    while (slvSmbusEn !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk1(n <= LINK && n <= CFG, 1'b1);
    chk1(stackReset_n, !test);
    chk1(linkTrainEn, !test);
    chk1(cfgRetryEn, !test);
    chk1(mstSmbusEn, 1'b0);
    chk1(mstSmbusSlow, rnd[4]);
    chk({25'h0, slvSmbusAddr}, {25'h0, 1'b1, rnd[3], 1'b1, rnd[2:0], 1'b0});
    if (!test) send(1'b1, 3'b100);
    if (!test) send(1'b0, 3'b010);
    bus(1'b1, OFF_IRQEN, {28'h0, en});
    n = 0;
    do begin
      rd(OFF_SWSTAT, 32'h0, 32'h0);
      n++;
    end while (q[SW_NORMAL_BIT] !== 1'b1 && q[SW_HALTED_BIT] !== 1'b1 && n < 60);
    if (q[SW_NORMAL_BIT] !== 1'b1 && q[SW_HALTED_BIT] !== 1'b1) failures++;
    chk1(q[SW_HALTED_BIT], halt);
    chk1(eeSeen, ee);
    rd(OFF_SMBSTAT, err ? 32'hF3 : 32'h3, {24'h0, failCode, 2'b0, ee && err, ee});
    rd(OFF_STRAPS, 32'h1FF, {23'h0, mode, rnd[4], rnd[3:0]});
    if (halt) begin
      chk1(coreReset_n, 1'b0);
      rd(OFF_CTRL, 32'h1, 32'h1);
      if (!test) send(1'b1, 3'b100);
      reset_halt <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk1(coreReset_n, 1'b0);
      bus(1'b1, OFF_CTRL, 32'h0);
    end
    waitcore();
    chk1(coreReset_n, 1'b1);
    rd(OFF_SWSTAT, 32'hF7, {31'h41, pin});
    if (!test) send(1'b0, 3'b001);
    repeat (2) @(posedge clk_sys);
    chk1(irq, |(ev & en)); // level output follows enabled status
    rd(OFF_IRQSTAT, 32'hF, {28'h0, ev});
    bus(1'b1, OFF_IRQCLR, 32'hF);
    repeat (2) @(posedge clk_sys);
    chk1(irq, 1'b0);
    rd(OFF_IRQSTAT, 32'hF, 32'h0);
  endtask : run

  // main sequence: reset, idle register values, then each mode in turn
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(5'h1C, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    rd(5'h1C, 32'hFFFF_FFFF, 32'h0);
    rd(OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    rd(OFF_SMBSTAT, 32'hFFFF_FFFF, 32'h0);
    run(4'h0, 1'b0, 1'b0, 4'h8);
    run(4'h1, 1'b0, 1'b0, 4'h0);
    run(4'h1, 1'b0, 1'b1, 4'h6);
    run(4'h0, 1'b1, 1'b0, 4'hF);
    run(4'h9, 1'b0, 1'b0, 4'h8);
    report_and_stop();
  end

  // watchdog: the whole run needs well under this
  initial begin
    #5_000_000;
    failures++;
    report_and_stop();
  end
endmodule : fundamental_reset_init_tail_bench
`default_nettype wire
